/* rtl/hsc_defines.vh */
`ifndef HSC_DEFINES_VH
`define HSC_DEFINES_VH

// Timing, expressed in printed units and converted to clock cycles.
`define HSC_CLK_MHZ 200
`define HSC_TICK_MS 1
`define HSC_TICK_CYC (`HSC_CLK_MHZ * 1000 * `HSC_TICK_MS)
`define HSC_TIMEOUT_MS 200
`define HSC_TIMEOUT_CYC (`HSC_CLK_MHZ * 1000 * `HSC_TIMEOUT_MS)
`define HSC_CARRIER_KHZ 20
`define HSC_CARRIER_CYC (`HSC_CLK_MHZ * 1000 / `HSC_CARRIER_KHZ)
`define HSC_DEAD_NS 1000
`define HSC_DEAD_CYC ((`HSC_DEAD_NS * `HSC_CLK_MHZ + 999) / 1000)

// Widths.
`define HSC_CNT_W 32
`define HSC_DEAD_W 8
`define HSC_ADDR_W 5
`define HSC_DATA_W 32
`define HSC_DUTY_W 16
`define HSC_EV_W 6

// Register byte offsets.
`define HSC_OFS_CTRL 5'h00
`define HSC_OFS_DUTY 5'h04
`define HSC_OFS_PINSEL 5'h08
`define HSC_OFS_STATUS 5'h0c
`define HSC_OFS_MASK 5'h10
`define HSC_OFS_SPEED 5'h14
`define HSC_OFS_STATE 5'h18
`define HSC_OFS_TIMER 5'h1c

// Field positions and reset values.
`define HSC_CTRL_DIR 0
`define HSC_DUTY_RST 16'h0000
`define HSC_MODE_RST 6'h3f
`define HSC_LVL_RST 6'h00
`define HSC_PINSEL_LVL_LSB 8
`define HSC_MASK_RST 6'h00

// Status bits.
`define HSC_EV_POS 0
`define HSC_EV_TICK 1
`define HSC_EV_OVC 2
`define HSC_EV_SHORT 3
`define HSC_EV_TMO 4
`define HSC_EV_HALL 5

// Hall codes that never occur on a healthy sensor set.
`define HSC_HALL_LOW 3'h0
`define HSC_HALL_HIGH 3'h7

`endif

/* rtl/hsc_interval.v */
`include "hsc_defines.vh"

module hsc_interval #(
  parameter [`HSC_CNT_W-1:0] PERIOD = 32'h0000000a
) (
  input wire clock,
  input wire reset_n,
  output reg [`HSC_CNT_W-1:0] count_q,
  output reg wrap_q
);

  wire last;

  assign last = (count_q == PERIOD - 32'h00000001);

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 32'h00000000;
      wrap_q <= 1'b0;
    end else begin
      count_q <= last ? 32'h00000000 : count_q + 32'h00000001;
      wrap_q <= last;
    end
  end

endmodule // hsc_interval

/* rtl/hsc_deadband.v */
`include "hsc_defines.vh"

module hsc_deadband (
  input wire clock,
  input wire reset_n,
  input wire demand,
  output reg high_q,
  output reg low_q
);

  localparam [`HSC_CNT_W-1:0] DEAD_FULL = `HSC_DEAD_CYC;
  localparam [`HSC_DEAD_W-1:0] DEAD = DEAD_FULL[`HSC_DEAD_W-1:0];

  reg demand_q;
  reg [`HSC_DEAD_W-1:0] dead_q;

  // Both switches stay off for the dead time after every change of demand.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      demand_q <= 1'b0;
      dead_q <= DEAD;
      high_q <= 1'b0;
      low_q <= 1'b0;
    end else if (demand != demand_q) begin
      demand_q <= demand;
      dead_q <= DEAD;
      high_q <= 1'b0;
      low_q <= 1'b0;
    end else if (dead_q != {`HSC_DEAD_W{1'b0}}) begin
      dead_q <= dead_q - {{(`HSC_DEAD_W-1){1'b0}}, 1'b1};
    end else begin
      high_q <= demand_q;
      low_q <= ~demand_q;
    end
  end

endmodule // hsc_deadband

/* rtl/hsc_top.v */
// Contract
// - Every rising and falling edge of each hall input raises a position event.
// - A position event captures speed, samples hall code and updates conduction pattern.
// - Falling edge on the overcurrent input releases all six gate pins.
// - A short between complementary gate outputs releases all six gate pins.
// - A dedicated timer gives a tick every 1 ms.
// - A free-running timer with no interrupt measures the interval between events.
// - Complementary PWM for all three phases, with dead time and active-high polarity.
// - A hardware trigger starts the analog sample-and-hold scan.
// - Run indicator is on while rotating and off while stopped.
// - Fault indicator is on while an error is latched.
// - A toggle switch input gives the start/stop command.
// - A second toggle switch clears the latched error.
// - Each gate pin selects static port level or PWM drive.
// - Low on the start/stop switch requests rotation, high requests stop.
// - No position event within 200 ms while rotating disables gates and flags error.
// - An invalid hall code disables gates and flags error.
// - The PWM carrier runs at 20 kHz.
`include "hsc_defines.vh"

module hsc_top #(
  parameter [`HSC_CNT_W-1:0] TICK_CYCLES = `HSC_TICK_CYC,
  parameter [`HSC_CNT_W-1:0] TIMEOUT_CYCLES = `HSC_TIMEOUT_CYC,
  parameter [`HSC_CNT_W-1:0] CARRIER_CYCLES = `HSC_CARRIER_CYC
) (
  input wire clock,
  input wire reset_n,
  input wire hall_phase_a,
  input wire hall_phase_b,
  input wire hall_phase_c,
  input wire overcurrent_stop_n,
  input wire run_stop_switch,
  input wire fault_clear_switch,
  input wire [`HSC_ADDR_W-1:0] reg_addr,
  input wire [`HSC_DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`HSC_DATA_W-1:0] reg_rdata,
  output wire gate_high_a,
  output wire gate_high_b,
  output wire gate_high_c,
  output wire gate_low_a,
  output wire gate_low_b,
  output wire gate_low_c,
  output wire gate_high_a_oe,
  output wire gate_high_b_oe,
  output wire gate_high_c_oe,
  output wire gate_low_a_oe,
  output wire gate_low_b_oe,
  output wire gate_low_c_oe,
  output reg run_indicator,
  output reg fault_indicator,
  output reg adc_trigger,
  output reg tick_1ms,
  output reg irq
);

  // Pin vectors: bits 0..2 are upper switches a..c, bits 3..5 lower a..c.
  reg [5:0] gate_q;
  wire [5:0] gate_d;
  reg gate_oe_q;

  reg ctrl_dir_q;
  reg [`HSC_DUTY_W-1:0] duty_q;
  reg [5:0] pin_mode_q;
  reg [5:0] pin_level_q;
  reg [`HSC_EV_W-1:0] status_q;
  reg [`HSC_EV_W-1:0] status_d;
  reg [`HSC_EV_W-1:0] mask_q;

  reg primed_q;
  reg [2:0] hall_prev_q;
  reg [2:0] hall_code_q;
  reg ovc_prev_q;
  reg clear_prev_q;
  reg run_q;
  reg fault_q;
  reg [5:0] pattern_q;
  reg [`HSC_CNT_W-1:0] free_q;
  reg [`HSC_CNT_W-1:0] last_stamp_q;
  reg [`HSC_CNT_W-1:0] speed_q;
  reg [`HSC_CNT_W-1:0] silence_q;

  wire [2:0] hall_now;
  wire pos_event;
  wire ovc_event;
  wire clear_event;
  wire run_request;
  wire start_event;
  wire hall_bad;
  wire timeout_event;
  wire short_event;
  wire [`HSC_CNT_W-1:0] carrier_count;
  wire carrier_wrap;
  wire tick_wrap;
  wire pwm_on;
  wire [2:0] db_high;
  wire [2:0] db_low;
  wire [5:0] pattern_next;
  wire [`HSC_EV_W-1:0] events;
  wire status_read;

  assign hall_now = {hall_phase_c, hall_phase_b, hall_phase_a};

  assign pos_event = primed_q && (hall_now != hall_prev_q);

  assign ovc_event = ovc_prev_q && !overcurrent_stop_n;

  assign clear_event = primed_q && (fault_clear_switch != clear_prev_q);

  assign run_request = !run_stop_switch;

  assign start_event = run_request && !run_q && !fault_q;

  assign hall_bad = pos_event &&
                    (hall_now == `HSC_HALL_LOW || hall_now == `HSC_HALL_HIGH);

  assign timeout_event = run_q && (silence_q == TIMEOUT_CYCLES - 32'h00000001);

  function [5:0] commutate;
    input [2:0] code;
    input reverse;
    reg [5:0] hl;
    begin
      case (code)
        3'h1: hl = {3'h1, 3'h2};
        3'h3: hl = {3'h1, 3'h4};
        3'h2: hl = {3'h2, 3'h4};
        3'h6: hl = {3'h2, 3'h1};
        3'h4: hl = {3'h4, 3'h1};
        3'h5: hl = {3'h4, 3'h2};
        default: hl = 6'h00;
      endcase
      // Reversal swaps which phase is sourced and which is sunk.
      commutate = reverse ? hl : {hl[2:0], hl[5:3]};
    end
  endfunction

  assign pattern_next = commutate(hall_now, ctrl_dir_q);

  hsc_interval #(
    .PERIOD(CARRIER_CYCLES)
  ) u_carrier (
    .clock(clock),
    .reset_n(reset_n),
    .count_q(carrier_count),
    .wrap_q(carrier_wrap)
  );

  hsc_interval #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .reset_n(reset_n),
    .count_q(),
    .wrap_q(tick_wrap)
  );

  assign pwm_on = carrier_count < {{(`HSC_CNT_W-`HSC_DUTY_W){1'b0}}, duty_q};

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_phase
      hsc_deadband u_db (
        .clock(clock),
        .reset_n(reset_n),
        .demand(pwm_on),
        .high_q(db_high[p]),
        .low_q(db_low[p])
      );

      // The chopped phase gets complementary PWM; the sinking phase holds its lower switch.
      // port or PWM select
      assign gate_d[p] = pin_mode_q[p] ? (pattern_q[p] & db_high[p]) : pin_level_q[p];
      assign gate_d[p+3] = pin_mode_q[p+3] ? ((pattern_q[p] & db_low[p]) | pattern_q[p+3]) :
                           pin_level_q[p+3];
    end
  endgenerate

  assign short_event = |(gate_d[2:0] & gate_d[5:3]);

  assign events = {hall_bad, timeout_event, short_event, ovc_event, tick_wrap, pos_event};
  assign status_read = reg_read && (reg_addr == `HSC_OFS_STATUS);

  // A read clears the status, but an event in the same cycle survives it.
  always @* begin
    status_d = (status_read ? {`HSC_EV_W{1'b0}} : status_q) | events;
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      primed_q <= 1'b0;
      hall_prev_q <= 3'h0;
      ovc_prev_q <= 1'b1;
      clear_prev_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
      hall_prev_q <= hall_now;
      ovc_prev_q <= overcurrent_stop_n;
      clear_prev_q <= fault_clear_switch;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      free_q <= 32'h00000000;
      last_stamp_q <= 32'h00000000;
      speed_q <= 32'h00000000;
      hall_code_q <= 3'h0;
      pattern_q <= 6'h00;
    end else begin
      free_q <= free_q + 32'h00000001;
      if (pos_event) begin
        speed_q <= free_q - last_stamp_q;
        last_stamp_q <= free_q;
        hall_code_q <= hall_now;
      end
      if (pos_event || start_event) begin
        pattern_q <= pattern_next;
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      silence_q <= 32'h00000000;
    end else if (!run_q || pos_event || timeout_event) begin
      silence_q <= 32'h00000000;
    end else begin
      silence_q <= silence_q + 32'h00000001;
    end
  end

  // clear loses to a new fault
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fault_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (ovc_event || short_event || timeout_event || hall_bad) begin
        fault_q <= 1'b1;
      end else if (clear_event) begin
        fault_q <= 1'b0;
      end
      run_q <= run_request && !fault_q &&
               !(ovc_event || short_event || timeout_event || hall_bad);
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gate_q <= 6'h00;
      gate_oe_q <= 1'b0;
    end else begin
      // A shorted pin set is never latched, so the pins cannot show it even for a cycle.
      gate_q <= short_event ? 6'h00 : gate_d;
      gate_oe_q <= run_q && !fault_q &&
                   !(ovc_event || short_event || timeout_event || hall_bad);
    end
  end

  assign gate_high_a = gate_q[0];
  assign gate_high_b = gate_q[1];
  assign gate_high_c = gate_q[2];
  assign gate_low_a = gate_q[3];
  assign gate_low_b = gate_q[4];
  assign gate_low_c = gate_q[5];
  assign gate_high_a_oe = gate_oe_q;
  assign gate_high_b_oe = gate_oe_q;
  assign gate_high_c_oe = gate_oe_q;
  assign gate_low_a_oe = gate_oe_q;
  assign gate_low_b_oe = gate_oe_q;
  assign gate_low_c_oe = gate_oe_q;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_indicator <= 1'b0;
      fault_indicator <= 1'b0;
      adc_trigger <= 1'b0;
      tick_1ms <= 1'b0;
      irq <= 1'b0;
    end else begin
      run_indicator <= run_q;
      fault_indicator <= fault_q;
      adc_trigger <= carrier_wrap && run_q;
      tick_1ms <= tick_wrap;
      irq <= |(status_d & mask_q);
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_dir_q <= 1'b0;
      duty_q <= `HSC_DUTY_RST;
      pin_mode_q <= `HSC_MODE_RST;
      pin_level_q <= `HSC_LVL_RST;
      mask_q <= `HSC_MASK_RST;
      status_q <= {`HSC_EV_W{1'b0}};
    end else begin
      status_q <= status_d;
      if (reg_write) begin
        if (reg_addr == `HSC_OFS_CTRL) begin
          ctrl_dir_q <= reg_wdata[`HSC_CTRL_DIR];
        end else if (reg_addr == `HSC_OFS_DUTY) begin
          duty_q <= reg_wdata[`HSC_DUTY_W-1:0];
        end else if (reg_addr == `HSC_OFS_PINSEL) begin
          pin_mode_q <= reg_wdata[5:0];
          pin_level_q <= reg_wdata[`HSC_PINSEL_LVL_LSB+5:`HSC_PINSEL_LVL_LSB];
        end else if (reg_addr == `HSC_OFS_MASK) begin
          mask_q <= reg_wdata[`HSC_EV_W-1:0];
        end
      end
    end
  end

  // Read data is valid only in the cycle after the strobe; unmapped reads give zero.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_read) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == `HSC_OFS_CTRL) begin
      reg_rdata <= {31'h00000000, ctrl_dir_q};
    end else if (reg_addr == `HSC_OFS_DUTY) begin
      reg_rdata <= {16'h0000, duty_q};
    end else if (reg_addr == `HSC_OFS_PINSEL) begin
      reg_rdata <= {18'h00000, pin_level_q, 2'h0, pin_mode_q};
    end else if (reg_addr == `HSC_OFS_STATUS) begin
      reg_rdata <= {26'h0000000, status_q};
    end else if (reg_addr == `HSC_OFS_MASK) begin
      reg_rdata <= {26'h0000000, mask_q};
    end else if (reg_addr == `HSC_OFS_SPEED) begin
      reg_rdata <= speed_q;
    end else if (reg_addr == `HSC_OFS_STATE) begin
      reg_rdata <= {16'h0000, pattern_q, 3'h0, hall_code_q, 2'h0, fault_q, run_q};
    end else if (reg_addr == `HSC_OFS_TIMER) begin
      reg_rdata <= free_q;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // hsc_top

/* tb/hsc_top_properties.sv */
`include "hsc_defines.vh"

module hsc_checker #(
  parameter [`HSC_CNT_W-1:0] TICK_CYCLES = 32'h00000032
) (
  input wire clock,
  input wire reset_n,
  input wire hall_phase_a,
  input wire hall_phase_b,
  input wire hall_phase_c,
  input wire overcurrent_stop_n,
  input wire run_stop_switch,
  input wire gate_high_a,
  input wire gate_high_b,
  input wire gate_high_c,
  input wire gate_low_a,
  input wire gate_low_b,
  input wire gate_low_c,
  input wire gate_high_a_oe,
  input wire gate_high_b_oe,
  input wire gate_high_c_oe,
  input wire gate_low_a_oe,
  input wire gate_low_b_oe,
  input wire gate_low_c_oe,
  input wire run_indicator,
  input wire fault_indicator,
  input wire adc_trigger,
  input wire tick_1ms
);
  wire [2:0] hall_w = {hall_phase_c, hall_phase_b, hall_phase_a};
  wire [5:0] gate_w = {gate_low_c, gate_low_b, gate_low_a, gate_high_c, gate_high_b, gate_high_a};
  wire [5:0] oe_w = {gate_low_c_oe, gate_low_b_oe, gate_low_a_oe,
                     gate_high_c_oe, gate_high_b_oe, gate_high_a_oe};
  reg [`HSC_CNT_W-1:0] gap_q;
  reg seen_q;

  // The first tick has no reference, so spacing is judged only after it.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= tick_1ms ? 32'h1 : gap_q + 32'h1;
      seen_q <= seen_q | tick_1ms;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  oe_uniform_a: assert property (oe_w == 6'h00 || oe_w == 6'h3f)
    else $error("gate enables disagree");
  ovc_release_a: assert property ($fell(overcurrent_stop_n) |-> ##[1:3] (oe_w == 6'h00 && fault_indicator))
    else $error("overcurrent did not release gates");
  no_shoot_a: assert property ((gate_w[2:0] & gate_w[5:3]) == 3'h0)
    else $error("upper and lower of one phase both on");
  fault_hold_a: assert property (fault_indicator && $past(fault_indicator) |-> oe_w == 6'h00)
    else $error("gates driven while fault latched");
  idle_gates_a: assert property (!run_indicator && !$past(run_indicator) |-> oe_w == 6'h00)
    else $error("gates driven while stopped");
  stop_switch_a: assert property ($rose(run_stop_switch) |-> ##[1:3] !run_indicator)
    else $error("stop request ignored");
  bad_hall_a: assert property (hall_w != $past(hall_w) && (hall_w == 3'h0 || hall_w == 3'h7)
      |-> ##[1:3] fault_indicator)
    else $error("invalid hall code not flagged");
  adc_pulse_a: assert property (adc_trigger |=> !adc_trigger)
    else $error("converter trigger longer than one cycle");
  tick_gap_a: assert property (seen_q |-> (tick_1ms ? gap_q == TICK_CYCLES : gap_q < TICK_CYCLES))
    else $error("tick spacing wrong");
endmodule // hsc_checker

bind hsc_top hsc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
  .clock(clock), .reset_n(reset_n), .hall_phase_a(hall_phase_a), .hall_phase_b(hall_phase_b),
  .hall_phase_c(hall_phase_c), .overcurrent_stop_n(overcurrent_stop_n),
  .run_stop_switch(run_stop_switch), .gate_high_a(gate_high_a), .gate_high_b(gate_high_b),
  .gate_high_c(gate_high_c), .gate_low_a(gate_low_a), .gate_low_b(gate_low_b),
  .gate_low_c(gate_low_c), .gate_high_a_oe(gate_high_a_oe), .gate_high_b_oe(gate_high_b_oe),
  .gate_high_c_oe(gate_high_c_oe), .gate_low_a_oe(gate_low_a_oe),
  .gate_low_b_oe(gate_low_b_oe), .gate_low_c_oe(gate_low_c_oe),
  .run_indicator(run_indicator), .fault_indicator(fault_indicator),
  .adc_trigger(adc_trigger), .tick_1ms(tick_1ms)
);

/* tb/hsc_motor_model.sv */
module hsc_motor_model (
  input wire clock,
  input wire [2:0] code,
  input wire [5:0] gate,
  input wire [5:0] gate_oe,
  output reg hall_phase_a,
  output reg hall_phase_b,
  output reg hall_phase_c,
  output wire [5:0] pin_level
);
  timeunit 1ns;
  timeprecision 100ps;

  always @(posedge clock) begin
    {hall_phase_c, hall_phase_b, hall_phase_a} <= code;
  end

  // Released gate pins fall to the driver's pull-down, so a floating pin reads low.
  assign pin_level = gate & gate_oe;
endmodule // hsc_motor_model

/* tb/hsc_top_tb.sv */
`include "hsc_defines.vh"

module hsc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [17:0] SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  reg clock, reset_n, overcurrent_stop_n, run_stop_switch, fault_clear_switch;
  reg reg_write, reg_read;
  reg [4:0] reg_addr;
  reg [31:0] reg_wdata, d, seed;
  reg [2:0] code, c;
  wire [31:0] reg_rdata;
  wire hall_phase_a, hall_phase_b, hall_phase_c, run_indicator, fault_indicator;
  wire adc_trigger, tick_1ms, irq;
  wire [5:0] gate, oe, pins;
  integer n_fail, check_count, i, k;
  time t_prev, t_last;

  hsc_top #(.TICK_CYCLES(32'd50), .TIMEOUT_CYCLES(32'd2000), .CARRIER_CYCLES(32'd64)) dut (
    .clock(clock), .reset_n(reset_n), .hall_phase_a(hall_phase_a),
    .hall_phase_b(hall_phase_b), .hall_phase_c(hall_phase_c),
    .overcurrent_stop_n(overcurrent_stop_n), .run_stop_switch(run_stop_switch),
    .fault_clear_switch(fault_clear_switch), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .gate_high_a(gate[0]), .gate_high_b(gate[1]), .gate_high_c(gate[2]),
    .gate_low_a(gate[3]), .gate_low_b(gate[4]), .gate_low_c(gate[5]),
    .gate_high_a_oe(oe[0]), .gate_high_b_oe(oe[1]), .gate_high_c_oe(oe[2]),
    .gate_low_a_oe(oe[3]), .gate_low_b_oe(oe[4]), .gate_low_c_oe(oe[5]),
    .run_indicator(run_indicator), .fault_indicator(fault_indicator),
    .adc_trigger(adc_trigger), .tick_1ms(tick_1ms), .irq(irq)
  );

  hsc_motor_model u_motor (
    .clock(clock), .code(code), .gate(gate), .gate_oe(oe), .hall_phase_a(hall_phase_a),
    .hall_phase_b(hall_phase_b), .hall_phase_c(hall_phase_c), .pin_level(pins)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task wr(input [4:0] a, input [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task rd(input [4:0] a, output [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask

  function cond(input integer sel);
    case (sel)
      0: cond = run_indicator === 1'b1;
      1: cond = fault_indicator === 1'b1;
      2: cond = tick_1ms === 1'b1;
      3: cond = run_indicator === 1'b0;
      default: cond = fault_indicator === 1'b0;
    endcase
  endfunction

  task wait_on(input integer sel, input integer limit);
    integer n;
    n = 0;
    while (!cond(sel) && n < limit) begin
      @(negedge clock);
      n = n + 1;
    end
    check_count = check_count + 1;
    if (!cond(sel)) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: wait %0d ran out", $time, sel);
      report_and_stop;
    end
  endtask

  // One upper and one lower switch; index 0..2 is phase a..c.
  function [5:0] expect_pat(input [2:0] h, input rev);
    reg [2:0] up, dn, t;
    case (h)
      3'h1: begin up = 0; dn = 1; end
      3'h3: begin up = 0; dn = 2; end
      3'h2: begin up = 1; dn = 2; end
      3'h6: begin up = 1; dn = 0; end
      3'h4: begin up = 2; dn = 0; end
      default: begin up = 2; dn = 1; end
    endcase
    if (rev) begin
      t = up;
      up = dn;
      dn = t;
    end
    expect_pat = (6'h01 << up) | (6'h08 << dn);
  endfunction

  task recover;
    @(posedge clock);
    fault_clear_switch <= ~fault_clear_switch;
    wait_on(4, 10);
    wait_on(0, 20);
  endtask

  initial begin
    seed = 32'haa1c;
    n_fail = 0;
    check_count = 0;
    {reset_n, reg_write, reg_read, fault_clear_switch} = 4'h0;
    {overcurrent_stop_n, run_stop_switch} = 2'h3;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    code = 3'h5;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    check(oe, 6'h00);
    rd(`HSC_OFS_PINSEL, d);
    check(d, 32'h0000003f);
    wr(5'h02, 32'h00000001);
    rd(5'h02, d);
    check(d, 32'h0);
    rd(`HSC_OFS_CTRL, d);
    check(d, 32'h0);
    wait_on(2, 60);
    rd(`HSC_OFS_STATUS, d);
    check(d[1], 1'b1);
    $display("registers and tick done");
    wr(`HSC_OFS_DUTY, 32'h0000ffff);
    wr(`HSC_OFS_MASK, 32'h00000001);
    @(posedge clock);
    run_stop_switch <= 1'b0;
    wait_on(0, 20);
    rd(`HSC_OFS_STATUS, d);
    for (i = 0; i < 12; i = i + 1) begin
      if (i == 6) wr(`HSC_OFS_CTRL, 32'h00000001);
      c = SEQ[3 * (i % 6) +: 3];
      @(posedge clock);
      code <= c;
      t_prev = t_last;
      t_last = $time;
      repeat (210 + ($random(seed) & 63)) @(negedge clock);
      check(pins, expect_pat(c, i > 5));
      check(irq, 1'b1);
      rd(`HSC_OFS_STATUS, d);
      check(d[0], 1'b1);
      rd(`HSC_OFS_SPEED, d);
      if (i > 0) check(d, 32'((t_last - t_prev) / 5));
      rd(`HSC_OFS_STATE, d);
      check(d[6:4], c);
      check(irq, 1'b0);
    end
    k = 0;
    repeat (256) begin
      @(negedge clock);
      if (adc_trigger === 1'b1) k = k + 1;
    end
    check(k, 4);
    $display("commutation done");
    wr(`HSC_OFS_PINSEL, 32'h00001100);
    repeat (210) @(negedge clock);
    check(pins, 6'h11);
    wr(`HSC_OFS_PINSEL, 32'h00000900);
    wait_on(1, 10);
    check(oe, 6'h00);
    wr(`HSC_OFS_PINSEL, 32'h0000003f);
    recover;
    wait_on(1, 2100);
    check(oe, 6'h00);
    recover;
    @(posedge clock);
    overcurrent_stop_n <= 1'b0;
    wait_on(1, 10);
    @(posedge clock);
    overcurrent_stop_n <= 1'b1;
    recover;
    @(posedge clock);
    code <= 3'h7;
    wait_on(1, 10);
    @(posedge clock);
    code <= 3'h1;
    recover;
    $display("protection done");
    @(posedge clock);
    run_stop_switch <= 1'b1;
    wait_on(3, 10);
    repeat (2) @(negedge clock);
    check(oe, 6'h00);
    $display("stop done");
    report_and_stop;
  end
endmodule // hsc_top_tb
